// *** pkg/literal_move_consts.vh ***
// constants for the literal, move and indirect-store instruction group
`ifndef LITERAL_MOVE_CONSTS_VH
`define LITERAL_MOVE_CONSTS_VH

// 14-bit opcode patterns
`define OP_NO_OPERATION     14'h0000
`define OP_RESET            14'h0001
`define OP_OPTION           14'h0062
`define OP_STORE_FILE_MASK  14'h3f80
`define OP_STORE_FILE_VAL   14'h0080
`define OP_LOAD_W_MASK      14'h3f00
`define OP_LOAD_W_VAL       14'h3000
`define OP_LOAD_BANK_MASK   14'h3fe0
`define OP_LOAD_BANK_VAL    14'h0020
`define OP_LOAD_LATCH_MASK  14'h3f80
`define OP_LOAD_LATCH_VAL   14'h3180
`define OP_STORE_IND_MASK   14'h3ff8
`define OP_STORE_IND_VAL    14'h0018
`define OP_STORE_OFS_MASK   14'h3f80
`define OP_STORE_OFS_VAL    14'h3f80

// field positions
`define FLD_INDEX_BIT   2
`define FLD_KIDX_BIT    6
`define FLD_MODE_HI     1
`define FLD_MODE_LO     0

// pointer update modes
`define MODE_PRE_INC    2'h0
`define MODE_PRE_DEC    2'h1
`define MODE_POST_INC   2'h2
`define MODE_POST_DEC   2'h3

// file addresses of the two indirect data ports
`define ADDR_INDIRECT0  7'h00
`define ADDR_INDIRECT1  7'h01

// reset values
`define RST_OPTION      8'hff
`define RST_BANK        5'h00
`define RST_LATCH       7'h00
`define RST_W           8'h00
`define RST_POINTER     16'h0000

`endif

// *** verilog/literal_move_indirect_store_ops.v ***
// executes literal loads, direct/indirect stores, option load, no-op and software reset
// What this block does
// - bank literal loads bank select, flags kept
// - seven-bit literal loads program counter latch
// - eight-bit literal loads working register, one cycle
// - working register stored to addressed file register
// - indirect store address: pointer+1, -1, pointer itself (post modes), or +offset
// - mode 00 preinc, 01 predec, 10/11 post
// - pointer ends +1, -1, or unchanged for offset
// - indirect data port redirects through its pointer
// - pointer is sixteen bits, wraps both ways
// - pointer update and store touch no flags
// - option load copies working register, one cycle
// - software reset pulses reset, clears reset flag
`timescale 1ns/1ps
`default_nettype none
`include "literal_move_consts.vh"

module literal_move_indirect_store_ops (
    input  wire        sys_clk,
    input  wire        reset_n,
    input  wire        instr_valid,
    input  wire [13:0] instr_word,
    output reg         instr_done,
    output reg  [7:0]  working_reg,
    output reg  [4:0]  bank_select_reg,
    output reg  [6:0]  program_counter_high_latch,
    output reg  [7:0]  option_reg,
    output reg  [15:0] indirect_pointer0,
    output reg  [15:0] indirect_pointer1,
    output reg         mem_write,
    output reg  [15:0] mem_addr,
    output reg  [7:0]  mem_wdata,
    output reg         mem_linear,
    output reg         device_reset_req,
    output reg         reset_instruction_flag_n,
    output reg         status_write
);

// ----------------------------------------------------------------
// decode
// ----------------------------------------------------------------
wire is_reset      = instr_valid && (instr_word == `OP_RESET);
wire is_option     = instr_valid && (instr_word == `OP_OPTION);
wire is_load_bank  = instr_valid && ((instr_word & `OP_LOAD_BANK_MASK) == `OP_LOAD_BANK_VAL);
wire is_load_latch = instr_valid && ((instr_word & `OP_LOAD_LATCH_MASK) == `OP_LOAD_LATCH_VAL);
wire is_load_w     = instr_valid && ((instr_word & `OP_LOAD_W_MASK) == `OP_LOAD_W_VAL);
wire is_store_file = instr_valid && ((instr_word & `OP_STORE_FILE_MASK) == `OP_STORE_FILE_VAL);
wire is_wi_mod     = instr_valid && ((instr_word & `OP_STORE_IND_MASK) == `OP_STORE_IND_VAL);
wire is_wi_off     = instr_valid && ((instr_word & `OP_STORE_OFS_MASK) == `OP_STORE_OFS_VAL);

wire [1:0] mode = instr_word[`FLD_MODE_HI:`FLD_MODE_LO];
// a direct store to an indirect data port is redirected through its pointer
wire [6:0] file_addr   = instr_word[6:0];
wire       wf_indirect = is_store_file &&
                         (file_addr == `ADDR_INDIRECT0 || file_addr == `ADDR_INDIRECT1);

wire sel = is_wi_off ? instr_word[`FLD_KIDX_BIT] :
           is_wi_mod ? instr_word[`FLD_INDEX_BIT] : file_addr[0];
wire [15:0] ptr = sel ? indirect_pointer1 : indirect_pointer0;

// ----------------------------------------------------------------
// effective address and pointer update
// ----------------------------------------------------------------
wire [15:0] ptr_inc = ptr + 16'h0001;
wire [15:0] ptr_dec = ptr - 16'h0001;
wire [15:0] k_ext   = {{10{instr_word[5]}}, instr_word[5:0]};
wire [15:0] ptr_off = ptr + k_ext;

reg [15:0] next_addr;
reg [15:0] next_ptr;
always @* begin
    next_addr = ptr;
    next_ptr  = ptr;
    if (is_wi_off) begin
        next_addr = ptr_off;
        next_ptr  = ptr;
    end else if (is_wi_mod) begin
        case (mode)
            `MODE_PRE_INC: begin
                next_addr = ptr_inc;
                next_ptr  = ptr_inc;
            end
            `MODE_PRE_DEC: begin
                next_addr = ptr_dec;
                next_ptr  = ptr_dec;
            end
            `MODE_POST_INC: begin
                next_addr = ptr;
                next_ptr  = ptr_inc;
            end
            `MODE_POST_DEC: begin
                next_addr = ptr;
                next_ptr  = ptr_dec;
            end
            default: begin
                next_addr = ptr;
                next_ptr  = ptr;
            end
        endcase
    end
end

wire upd_ptr = is_wi_mod;

// ----------------------------------------------------------------
// state update; every instruction here is one word, one cycle
// ----------------------------------------------------------------
always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
        instr_done                 <= 1'b0;
        working_reg                <= `RST_W;
        bank_select_reg            <= `RST_BANK;
        program_counter_high_latch <= `RST_LATCH;
        option_reg                 <= `RST_OPTION;
        indirect_pointer0          <= `RST_POINTER;
        indirect_pointer1          <= `RST_POINTER;
        mem_write                  <= 1'b0;
        mem_addr                   <= 16'h0000;
        mem_wdata                  <= 8'h00;
        mem_linear                 <= 1'b0;
        device_reset_req           <= 1'b0;
        reset_instruction_flag_n   <= 1'b1;
        status_write               <= 1'b0;
    end else begin
        // none of these instructions alters a status flag
        status_write     <= 1'b0;
        instr_done       <= instr_valid;
        mem_write        <= 1'b0;
        device_reset_req <= 1'b0;
        if (is_load_bank)
            bank_select_reg <= instr_word[4:0];
        if (is_load_latch)
            program_counter_high_latch <= instr_word[6:0];
        if (is_load_w)
            working_reg <= instr_word[7:0];
        if (is_option)
            option_reg <= working_reg;
        if (is_store_file) begin
            mem_write  <= 1'b1;
            mem_wdata  <= working_reg;
            mem_linear <= wf_indirect;
            mem_addr   <= wf_indirect ? ptr : {9'h000, file_addr};
        end
        if (is_wi_mod || is_wi_off) begin
            mem_write  <= 1'b1;
            mem_wdata  <= working_reg;
            mem_linear <= 1'b1;
            mem_addr   <= next_addr;
        end
        if (upd_ptr && !sel)
            indirect_pointer0 <= next_ptr;
        if (upd_ptr && sel)
            indirect_pointer1 <= next_ptr;
        if (is_reset) begin
            // the reset pulse goes to the reset controller; the flag here is
            // kept only so software can tell a software reset happened
            device_reset_req         <= 1'b1;
            reset_instruction_flag_n <= 1'b0;
        end
    end
end

endmodule // literal_move_indirect_store_ops
`default_nettype wire

// *** sim/literal_ops_monitor.sv ***
// port assertions for the instruction group
`timescale 1ns/1ps
`default_nettype none
module literal_ops_monitor (
    input wire logic        sys_clk, reset_n, instr_valid, instr_done, mem_write, mem_linear,
    input wire logic        device_reset_req, reset_instruction_flag_n, status_write,
    input wire logic [13:0] instr_word,
    input wire logic [7:0]  working_reg, option_reg, mem_wdata,
    input wire logic [4:0]  bank_select_reg,
    input wire logic [6:0]  program_counter_high_latch,
    input wire logic [15:0] indirect_pointer0, indirect_pointer1, mem_addr
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // idle cycles map to a word outside this group so no antecedent fires
    wire [13:0] op = instr_valid ? instr_word : 14'h3e00;
    sequence s_pulse; device_reset_req && !reset_instruction_flag_n ##1 !device_reset_req; endsequence
    property p_bank; (op & 14'h3fe0) == 14'h0020 |=> bank_select_reg == $past(op[4:0]); endproperty
    property p_lit; (op & 14'h3f00) == 14'h3000 |=> working_reg == $past(op[7:0]); endproperty
    property p_store; (op & 14'h3f80) == 14'h0080 |=> mem_write && mem_wdata == $past(working_reg); endproperty
    property p_pre; op == 14'h0018 |=> indirect_pointer0 == $past(indirect_pointer0) + 16'h1 && mem_addr == indirect_pointer0; endproperty
    property p_offs; (op & 14'h3f80) == 14'h3f80 |=> mem_linear && $stable(indirect_pointer0) && $stable(indirect_pointer1); endproperty
    property p_opt; op == 14'h0062 |=> option_reg == $past(working_reg); endproperty
    property p_sreset; op == 14'h0001 |=> s_pulse; endproperty
    property p_no_op; op == 14'h0000 |=> instr_done && !mem_write && $stable(working_reg); endproperty
    property p_flags; !status_write; endproperty
    a_bank: assert property (p_bank) else $error("bank load");
    a_lit: assert property (p_lit) else $error("literal load");
    a_store: assert property (p_store) else $error("store");
    a_pre: assert property (p_pre) else $error("preincrement");
    a_offs: assert property (p_offs) else $error("offset form");
    a_opt: assert property (p_opt) else $error("option load");
    a_sreset: assert property (p_sreset) else $error("soft reset");
    a_no_op: assert property (p_no_op) else $error("no operation");
    a_flags: assert property (p_flags) else $error("flag write");
endmodule // literal_ops_monitor
`default_nettype wire

// *** sim/tb_top.sv ***
// self-checking bench for the literal, move and indirect-store group
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic sys_clk = 1'b0, reset_n = 1'b0, instr_valid = 1'b0;
    logic [13:0] instr_word = 14'h0000;
    wire instr_done, mem_write, mem_linear, device_reset_req, reset_instruction_flag_n, status_write;
    wire [7:0] working_reg, option_reg, mem_wdata;
    wire [4:0] bank_select_reg;
    wire [6:0] program_counter_high_latch;
    wire [15:0] indirect_pointer0, indirect_pointer1, mem_addr;
    int mismatches = 0;
    int comparisons = 0;
    always #10 sys_clk = ~sys_clk;
    literal_move_indirect_store_ops literal_move_indirect_store_ops_i (.*);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // entered at a falling edge; valid stays high so words run back to back
    task automatic ex(input logic [13:0] w);
        instr_valid = 1'b1;
        instr_word = w;
        @(negedge sys_clk);
        chk(instr_done, 16'h0001);
    endtask
    task automatic ind(input logic [13:0] w, input logic [15:0] a, p0, p1);
        ex(w);
        chk({status_write, mem_write, mem_linear, mem_wdata}, 16'h03a5);
        chk(mem_addr, a);
        chk(indirect_pointer0, p0);
        chk(indirect_pointer1, p1);
    endtask
    task automatic end_sim;
        if (mismatches == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #100us;
        mismatches++;
        end_sim;
    end
    initial begin
        repeat (2) @(negedge sys_clk);
        reset_n = 1'b1;
        chk({option_reg, 7'h00, reset_instruction_flag_n}, 16'hff01);
        ex(14'h002f);
        chk(bank_select_reg, 16'h000f);
        ex(14'h31ff);
        chk(program_counter_high_latch, 16'h007f);
        ex(14'h30a5);
        chk(working_reg, 16'h00a5);
        ex(14'h00c5);
        chk({mem_write, mem_linear, mem_wdata}, 16'h02a5);
        chk(mem_addr, 16'h0045);
        ex(14'h0062);
        chk(option_reg, 16'h00a5);
        ind(14'h0019, 16'hffff, 16'hffff, 16'h0000);
        ind(14'h0018, 16'h0000, 16'h0000, 16'h0000);
        ind(14'h001e, 16'h0000, 16'h0000, 16'h0001);
        ind(14'h001f, 16'h0001, 16'h0000, 16'h0000);
        ind(14'h001a, 16'h0000, 16'h0001, 16'h0000);
        ind(14'h3fa0, 16'hffe1, 16'h0001, 16'h0000);
        ind(14'h3fdf, 16'h001f, 16'h0001, 16'h0000);
        ind(14'h0080, 16'h0001, 16'h0001, 16'h0000);
        ind(14'h0081, 16'h0000, 16'h0001, 16'h0000);
        ex(14'h0000);
        chk({status_write, mem_write, working_reg}, 16'h00a5);
        ex(14'h303c);
        ex(14'h0090);
        chk(mem_wdata, 16'h003c);
        ex(14'h0001);
        chk({device_reset_req, reset_instruction_flag_n}, 16'h0002);
        instr_valid = 1'b0;
        @(negedge sys_clk);
        chk({device_reset_req, instr_done, reset_instruction_flag_n}, 16'h0000);
        reset_n = 1'b0;
        @(negedge sys_clk);
        reset_n = 1'b1;
        chk(reset_instruction_flag_n, 16'h0001);
        end_sim;
    end
endmodule // tb_top
bind literal_move_indirect_store_ops literal_ops_monitor literal_ops_monitor_i (.*);
`default_nettype wire
